// ### rtl/nvm_data_ctrl.sv
/*
  nonvolatile data memory controller: address, data and control registers, a 32 x 8
  array, a fetch cycle of one clock and a store cycle timed by the slow oscillator.
  assumes the cpu presents one access per cycle on sfrReq and that writeTick toggles
  from a free-running oscillator unrelated to mclk.
*/
// What this block does
// - holds 32 bytes, accessed one byte per operation via three registers
// - address register keeps five bits; upper three read as zero
// - data register is 8-bit read/write, source of stores, sink of fetches
// - no store cycle while store unlock bit 3 is zero
// - setting store start bit 2 begins store; hardware clears it at end
// - store start ignored unless store unlock already one before
// - no fetch cycle while fetch unlock bit 1 is zero
// - setting fetch start bit 0 loads data register, then bit clears
// - fetch start ignored unless fetch unlock already one before
// - fetched byte stays in data register until next fetch or cpu write to it
// - store duration comes from an oscillator asynchronous to mclk
// - reset clears the store unlock bit
// - control register only at indirect pointer 040H with bank one
// - store end sets done flag; request needs both enables, stack free
// - servicing clears the done flag and the global interrupt enable
`timescale 1ns/10ps
module nvm_data_ctrl #(
  parameter int WriteTicks = nvm_pkg::WRITE_TICKS
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // cpu register port
  input wire nvm_pkg::sfrReq_t sfrReq,
  output logic [7:0] sfrRdata,
  // slow oscillator level for the store timer
  input wire logic writeTick,
  // interrupt side
  input wire nvm_pkg::irqCtl_t irqCtl,
  output logic nvmDoneFlag,
  output logic irqRequest,
  output logic globalIrqClear,
  // cycle status
  output logic nvmBusy
);
  import nvm_pkg::*;

  typedef enum logic [1:0] {IDLE, FETCH, STORE} cyc_t;
  localparam int TICK_W = $clog2(WriteTicks + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(WriteTicks);

  logic [NVM_DATA_W-1:0] mem [NVM_DEPTH];

  cyc_t state_q, state_d;
  logic [NVM_ADDR_W-1:0] addr_q, addr_d;
  logic [7:0] data_q, data_d;
  logic storeUnlock_q, storeUnlock_d;
  logic fetchUnlock_q, fetchUnlock_d;
  logic storeStart_q, storeStart_d;
  logic fetchStart_q, fetchStart_d;
  logic [NVM_ADDR_W-1:0] capAddr_q, capAddr_d;
  logic [7:0] capData_q, capData_d;
  logic [TICK_W-1:0] ticks_q, ticks_d;
  logic doneFlag_q, doneFlag_d;
  logic [7:0] rdata_q, rdata_d;
  logic tickS1_q, tickS2_q, tickS3_q;
  logic tickEdge, storeDone, addrHit, dataHit, ctrlHit;
  logic ctrlWr, storeGo, fetchGo;
  logic [7:0] ctrlView;

  // register decode
  // control only indirect
  assign ctrlHit = sfrReq.indirect && sfrReq.bank == CTRL_BANK && sfrReq.addr == CTRL_OFS;
  assign addrHit = sfrReq.bank == ADDR_BANK && sfrReq.addr == ADDR_OFS;
  assign dataHit = sfrReq.bank == DATA_BANK && sfrReq.addr == DATA_OFS;
  assign ctrlWr = sfrReq.wr && ctrlHit;
  assign ctrlView = {4'h0, storeUnlock_q, storeStart_q, fetchUnlock_q, fetchStart_q};

  // start qualification uses unlock values held before this write
  // prior unlock needed
  assign storeGo = ctrlWr && state_q == IDLE && storeUnlock_q
                   && sfrReq.wdata[CTRL_STORE_START] && !sfrReq.wdata[CTRL_FETCH_START];
  assign fetchGo = ctrlWr && state_q == IDLE && fetchUnlock_q
                   && sfrReq.wdata[CTRL_FETCH_START] && !sfrReq.wdata[CTRL_STORE_START];

  // tick synchroniser, the first stage feeds only the second
  // asynchronous write timer
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tickS1_q <= 1'b0;
      tickS2_q <= 1'b0;
      tickS3_q <= 1'b0;
    end else begin
      tickS1_q <= writeTick;
      tickS2_q <= tickS1_q;
      tickS3_q <= tickS2_q;
    end
  end
  assign tickEdge = tickS2_q && !tickS3_q;

  assign storeDone = state_q == STORE && tickEdge && ticks_q == TICK_LAST - 1'b1;

  // next values of the cycle sequencer and registers
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    data_d = data_q;
    storeUnlock_d = storeUnlock_q;
    fetchUnlock_d = fetchUnlock_q;
    storeStart_d = storeStart_q;
    fetchStart_d = fetchStart_q;
    capAddr_d = capAddr_q;
    capData_d = capData_q;
    ticks_d = ticks_q;
    rdata_d = rdata_q;
    if (sfrReq.wr && addrHit) begin
      addr_d = sfrReq.wdata[NVM_ADDR_W-1:0];
    end
    if (sfrReq.wr && dataHit) begin
      data_d = sfrReq.wdata;
    end
    // unlock bits always writable; start bits owned by hardware once set
    if (ctrlWr) begin
      storeUnlock_d = sfrReq.wdata[CTRL_STORE_UNLOCK];
      fetchUnlock_d = sfrReq.wdata[CTRL_FETCH_UNLOCK];
    end
    case (state_q)
      IDLE: begin
        if (storeGo) begin
          storeStart_d = 1'b1;
          capAddr_d = addr_d;
          capData_d = data_d;
          ticks_d = '0;
          state_d = STORE;
        end else if (fetchGo) begin
          fetchStart_d = 1'b1;
          capAddr_d = addr_d;
          state_d = FETCH;
        end
      end
      FETCH: begin
        data_d = mem[capAddr_q];
        fetchStart_d = 1'b0;
        state_d = IDLE;
      end
      STORE: begin
        if (tickEdge) begin
          ticks_d = ticks_q + 1'b1;
        end
        if (storeDone) begin
          storeStart_d = 1'b0;
          state_d = IDLE;
        end
      end
      default: begin
        state_d = IDLE;
      end
    endcase
    // registered read answer, upper address bits read as zero
    if (sfrReq.rd) begin
      if (ctrlHit) begin
        rdata_d = ctrlView;
      end else if (addrHit) begin
        rdata_d = {3'h0, addr_q};
      end else if (dataHit) begin
        rdata_d = data_q;
      end else begin
        rdata_d = 8'h00;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= IDLE;
      addr_q <= ADDR_RST[NVM_ADDR_W-1:0];
      data_q <= DATA_RST;
      storeUnlock_q <= CTRL_RST[CTRL_STORE_UNLOCK];
      fetchUnlock_q <= CTRL_RST[CTRL_FETCH_UNLOCK];
      storeStart_q <= CTRL_RST[CTRL_STORE_START];
      fetchStart_q <= CTRL_RST[CTRL_FETCH_START];
      capAddr_q <= '0;
      capData_q <= 8'h00;
      ticks_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      data_q <= data_d;
      storeUnlock_q <= storeUnlock_d;
      fetchUnlock_q <= fetchUnlock_d;
      storeStart_q <= storeStart_d;
      fetchStart_q <= fetchStart_d;
      capAddr_q <= capAddr_d;
      capData_q <= capData_d;
      ticks_q <= ticks_d;
      rdata_q <= rdata_d;
    end
  end

  // array, not reset since it is nonvolatile
  // 32 x 8 array
  always_ff @(posedge mclk) begin
    if (storeDone) begin
      mem[capAddr_q] <= capData_q;
    end
  end

  // done flag: set wins over service or software clear
  // set at store end
  always_comb begin
    doneFlag_d = doneFlag_q;
    if (irqCtl.irqAck || irqCtl.flagClr) begin
      doneFlag_d = 1'b0;
    end
    if (storeDone) begin
      doneFlag_d = 1'b1;
    end
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      doneFlag_q <= 1'b0;
    end else begin
      doneFlag_q <= doneFlag_d;
    end
  end

  // outputs
  // request gating
  assign irqRequest = doneFlag_q && irqCtl.irqEnable && irqCtl.globalIrqEnable
                      && !irqCtl.stackFull;
  assign globalIrqClear = irqCtl.irqAck;
  assign nvmDoneFlag = doneFlag_q;
  assign sfrRdata = rdata_q;
  assign nvmBusy = state_q != IDLE;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence fetchAsk;
    ctrlWr && state_q == IDLE && sfrReq.wdata[CTRL_FETCH_START] && !sfrReq.wdata[CTRL_STORE_START];
  endsequence
  sequence storeAsk;
    ctrlWr && state_q == IDLE && sfrReq.wdata[CTRL_STORE_START] && !sfrReq.wdata[CTRL_FETCH_START];
  endsequence

  a_store_locked_out: assert property (storeAsk and !storeUnlock_q |=> state_q == IDLE)
    else $error("store began without prior unlock");
  a_fetch_locked_out: assert property (fetchAsk and !fetchUnlock_q |=> !fetchStart_q)
    else $error("fetch began without prior unlock");
  a_fetch_completes: assert property (fetchAsk and fetchUnlock_q
      |=> fetchStart_q ##1 !fetchStart_q && data_q == mem[$past(capAddr_q)])
    else $error("fetch did not load data and clear start");
  a_addr_top_zero: assert property (sfrReq.rd && addrHit |=> sfrRdata[7:5] == 3'h0)
    else $error("address upper bits not zero");
  a_done_one_cycle: assert property (storeDone |=> !storeDone)
    else $error("completion event longer than one cycle");
  a_end_sets_flag: assert property ($fell(storeStart_q) |-> doneFlag_q && state_q == IDLE)
    else $error("store end did not set done flag");
  a_set_beats_clear: assert property (storeDone && irqCtl.irqAck |=> doneFlag_q)
    else $error("done flag lost to clear");
  a_capture_held: assert property (state_q == STORE && $past(state_q) == STORE
      |-> $stable(capAddr_q) && $stable(capData_q))
    else $error("captured store values changed");
  a_data_kept: assert property (state_q == IDLE && !(sfrReq.wr && dataHit)
      |=> $stable(data_q))
    else $error("data register changed without operation");
  a_service_clears: assert property (irqCtl.irqAck && !storeDone |=> !doneFlag_q)
    else $error("service did not clear flag");
endmodule // nvm_data_ctrl

// ### rtl/nvm_pkg.sv
/*
  shared constants and types for the byte-wide nonvolatile data memory controller.
  assumes a cpu special-function-register port with bank select and an indirect flag.
*/
package nvm_pkg;
  // array geometry
  localparam int NVM_DEPTH = 32;
  localparam int NVM_ADDR_W = 5;
  localparam int NVM_DATA_W = 8;
  // register locations: address and data in bank 0, control at 040H in bank 1
  localparam logic [7:0] ADDR_OFS = 8'h1E;
  localparam logic [7:0] DATA_OFS = 8'h1F;
  localparam logic [7:0] CTRL_OFS = 8'h40;
  localparam logic ADDR_BANK = 1'b0;
  localparam logic DATA_BANK = 1'b0;
  localparam logic CTRL_BANK = 1'b1;
  // control field positions
  localparam int CTRL_STORE_UNLOCK = 3;
  localparam int CTRL_STORE_START = 2;
  localparam int CTRL_FETCH_UNLOCK = 1;
  localparam int CTRL_FETCH_START = 0;
  // reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // write timer ticks from the slow oscillator per write cycle
  localparam int WRITE_TICKS = 4;

  // one register access from the cpu
  typedef struct packed {
    logic wr;
    logic rd;
    logic indirect;
    logic bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfrReq_t;

  // interrupt side inputs
  typedef struct packed {
    logic irqEnable;
    logic globalIrqEnable;
    logic stackFull;
    logic irqAck;
    logic flagClr;
  } irqCtl_t;
endpackage

// ### tb/test_nvm_data_ctrl.sv
/*
  self-checking bench for the nonvolatile data memory controller: register access,
  refused starts, store and fetch cycles, done flag and interrupt outputs.
  assumes nvm_pkg and nvm_data_ctrl are compiled before this file.
*/
`timescale 1ns/10ps
module test_nvm_data_ctrl;
  import nvm_pkg::*;
  // stimulus
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic writeTick = 1'b0;
  sfrReq_t sfrReq = '0;
  irqCtl_t irqCtl = '0;
  // observed outputs
  logic [7:0] sfrRdata;
  logic nvmDoneFlag, irqRequest, globalIrqClear, nvmBusy;
  int bad_count = 0;
  int comparisons = 0;

  nvm_data_ctrl #(.WriteTicks(WRITE_TICKS)) uut (
    .mclk(mclk), .nrst(nrst), .sfrReq(sfrReq), .sfrRdata(sfrRdata),
    .writeTick(writeTick), .irqCtl(irqCtl), .nvmDoneFlag(nvmDoneFlag),
    .irqRequest(irqRequest), .globalIrqClear(globalIrqClear), .nvmBusy(nvmBusy)
  );

  // 100 MHz system clock
  always #5 mclk = ~mclk;
  // slow oscillator, phase unrelated to mclk
  always #37 writeTick = ~writeTick;

  // compare and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one-cycle write strobe
  task automatic reg_wr(input logic ind, input logic bnk, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge mclk);
    sfrReq <= '{wr: 1'b1, rd: 1'b0, indirect: ind, bank: bnk, addr: a, wdata: d};
    @(posedge mclk);
    sfrReq.wr <= 1'b0;
  endtask

  // one-cycle read strobe, answer taken a cycle later
  task automatic rd_chk(input logic ind, input logic bnk, input logic [7:0] a,
                        input logic [7:0] exp);
    @(posedge mclk);
    sfrReq <= '{wr: 1'b0, rd: 1'b1, indirect: ind, bank: bnk, addr: a, wdata: 8'h00};
    @(posedge mclk);
    sfrReq.rd <= 1'b0;
    @(posedge mclk);
    #1 chk(sfrRdata, exp);
  endtask

  // control register through the indirect path in bank one
  task automatic ctrl_wr(input logic [7:0] d);
    reg_wr(1'b1, 1'b1, CTRL_OFS, d);
  endtask

  // bounded wait for the cycle to end
  task automatic wait_idle;
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    while (nvmBusy !== 1'b0 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({7'h00, nvmBusy}, 8'h00);
  endtask

  // store, then disturb address and data while the cycle runs
  task automatic store(input logic [7:0] a, d, a2, d2);
    reg_wr(1'b0, 1'b0, ADDR_OFS, a);
    reg_wr(1'b0, 1'b0, DATA_OFS, d);
    irqCtl.globalIrqEnable <= 1'b0; // mask around start
    ctrl_wr(8'h08); // unlock, start follows
    ctrl_wr(8'h0C); // one start bit only
    irqCtl.globalIrqEnable <= 1'b1; // unmask once started
    reg_wr(1'b0, 1'b0, ADDR_OFS, a2);
    reg_wr(1'b0, 1'b0, DATA_OFS, d2);
    #1 chk({7'h00, nvmBusy}, 8'h01); // still timing
    rd_chk(1'b1, 1'b1, CTRL_OFS, 8'h0C);
    wait_idle; // stay awake until done
    chk({7'h00, nvmDoneFlag}, 8'h01);
    rd_chk(1'b1, 1'b1, CTRL_OFS, 8'h08);
  endtask

  // fetch one byte into a cleared data register
  task automatic fetch(input logic [7:0] a, exp);
    reg_wr(1'b0, 1'b0, DATA_OFS, 8'h00);
    reg_wr(1'b0, 1'b0, ADDR_OFS, a);
    ctrl_wr(8'h02);
    ctrl_wr(8'h03);
    wait_idle;
    rd_chk(1'b1, 1'b1, CTRL_OFS, 8'h02);
    rd_chk(1'b0, 1'b0, DATA_OFS, exp);
  endtask

  // verdict and end of run
  task automatic print_verdict;
    $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #200000;
    bad_count++;
    $display("watchdog expired");
    print_verdict;
  end

  // main sequence
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd_chk(1'b0, 1'b0, ADDR_OFS, ADDR_RST);
    rd_chk(1'b0, 1'b0, DATA_OFS, DATA_RST);
    rd_chk(1'b1, 1'b1, CTRL_OFS, CTRL_RST);
    $display("test reset values done");
    reg_wr(1'b0, 1'b0, ADDR_OFS, 8'hFF);
    rd_chk(1'b0, 1'b0, ADDR_OFS, 8'h1F);
    reg_wr(1'b0, 1'b0, DATA_OFS, 8'hA5);
    rd_chk(1'b0, 1'b0, DATA_OFS, 8'hA5);
    reg_wr(1'b0, 1'b1, CTRL_OFS, 8'h0A); // direct access misses
    rd_chk(1'b0, 1'b1, CTRL_OFS, 8'h00);
    rd_chk(1'b1, 1'b1, CTRL_OFS, 8'h00);
    $display("test register access done");
    ctrl_wr(8'h04);
    rd_chk(1'b1, 1'b1, CTRL_OFS, 8'h00);
    ctrl_wr(8'h01);
    rd_chk(1'b1, 1'b1, CTRL_OFS, 8'h00);
    rd_chk(1'b0, 1'b0, DATA_OFS, 8'hA5);
    ctrl_wr(8'h0A);
    ctrl_wr(8'h0F);
    rd_chk(1'b1, 1'b1, CTRL_OFS, 8'h0A); // both starts refused
    rd_chk(1'b0, 1'b0, DATA_OFS, 8'hA5);
    ctrl_wr(8'h00);
    $display("test refused starts done");
    irqCtl <= '{irqEnable: 1'b1, globalIrqEnable: 1'b1, stackFull: 1'b0,
                irqAck: 1'b0, flagClr: 1'b0};
    store(8'h05, 8'h3C, 8'h06, 8'h3C); // captured address
    chk({7'h00, irqRequest}, 8'h01);
    @(posedge mclk);
    irqCtl.stackFull <= 1'b1;
    #1 chk({7'h00, irqRequest}, 8'h00);
    @(posedge mclk);
    irqCtl <= '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    #1 chk({7'h00, globalIrqClear}, 8'h01);
    @(posedge mclk);
    irqCtl.irqAck <= 1'b0;
    #1 chk({7'h00, nvmDoneFlag}, 8'h00);
    $display("test store and interrupt done");
    store(8'h06, 8'h77, 8'h06, 8'h11); // captured data
    @(posedge mclk);
    irqCtl.flagClr <= 1'b1;
    @(posedge mclk);
    irqCtl.flagClr <= 1'b0;
    #1 chk({7'h00, nvmDoneFlag}, 8'h00);
    store(8'h1F, 8'hC3, 8'h1F, 8'hC3); // top location
    fetch(8'h05, 8'h3C);
    fetch(8'h06, 8'h77);
    fetch(8'h1F, 8'hC3);
    rd_chk(1'b0, 1'b0, ADDR_OFS, 8'h1F);
    rd_chk(1'b0, 1'b0, DATA_OFS, 8'hC3); // byte held
    $display("test fetch done");
    print_verdict;
  end
endmodule // test_nvm_data_ctrl
